// file: core/spi_link_pkg.sv
package spi_link_pkg;

    // opcodes, first byte of every frame
    localparam logic [7:0] OP_SET_LATCH   = 8'h06;
    localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] OP_STATUS_RD   = 8'h05;
    localparam logic [7:0] OP_STATUS_WR   = 8'h01;
    localparam logic [7:0] OP_MEM_RD      = 8'h03;
    localparam logic [7:0] OP_MEM_WR      = 8'h02;

    // array geometry
    localparam int          ADDR_W    = 13;
    localparam int          MEM_DEPTH = 8192;
    localparam int          BYTE_W    = 8;
    localparam logic [2:0]  LAST_BIT  = 3'h7;

    // status byte layout and reset value
    localparam int          STAT_LATCH_BIT = 1;
    localparam logic [7:0]  STAT_RESET     = 8'h00;

    // positions of the sampled pins in the slave's synchroniser vector
    localparam int          PIN_SEL   = 0;
    localparam int          PIN_SCK   = 1;
    localparam int          PIN_SI    = 2;
    localparam int          PIN_PAUSE = 3;
    localparam int          PIN_WP    = 4;
    localparam logic [4:0]  PIN_IDLE  = 5'h19;

    // link timing, master side divider
    localparam int          CLK_PERIOD_NS   = 40;
    localparam int          SCK_HALF_NS     = 160;
    localparam int          SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  HALF_LAST       = 8'(SCK_HALF_CYCLES - 1);

    // slave command states, gray along opcode, address, write data
    typedef enum logic [2:0] {
        st_opcode  = 3'h0,
        st_addr_hi = 3'h1,
        st_addr_lo = 3'h3,
        st_write   = 3'h2,
        st_read    = 3'h6,
        st_stat_rd = 3'h7,
        st_stat_wr = 3'h5,
        st_ignore  = 3'h4
    } slave_state_type;

    // master sequencer states
    typedef enum logic [2:0] {
        m_idle = 3'h0,
        m_lead = 3'h1,
        m_low  = 3'h3,
        m_high = 3'h2,
        m_tail = 3'h6,
        m_gap  = 3'h7
    } master_state_type;

    // opcodes that carry a two byte address
    function automatic logic has_address(input logic [7:0] op);
        return (op == OP_MEM_RD) || (op == OP_MEM_WR);
    endfunction

    // opcodes whose data phase flows from slave to master
    function automatic logic is_read_op(input logic [7:0] op);
        return (op == OP_MEM_RD) || (op == OP_STATUS_RD);
    endfunction

endpackage

// file: core/spi_link_if.sv
`timescale 1ns/1ps
interface spi_link_if;
    logic sel_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic pause_n;
    logic wp_n;

    modport host (
        output sel_n,
        output sck,
        output mosi,
        output pause_n,
        output wp_n,
        input  miso,
        input  miso_oe
    );

    modport mem (
        input  sel_n,
        input  sck,
        input  mosi,
        input  pause_n,
        input  wp_n,
        output miso,
        output miso_oe
    );
endinterface

// file: core/mem_slave.sv
// What this block does
// - select high: output off, inputs ignored
// - respond only while selected; one opcode per select
// - capture on rising, drive on falling edge
// - static logic, clock may stop anytime
// - pause low freezes transaction, then resumes
// - master moves pause only while clock low
// - protect pin low blocks status writes
// - output driven only during read data
// - half duplex, never drive while receiving
// - 8192 bytes of eight bits
// - byte written once fully shifted in
// - no busy state after writes
// - only modes zero and three
// - opcode first; six opcode encodings
// - two address bytes, low 13 bits used
// - write latch: clear, set, auto-cleared
// - eight-bit groups, msb first
`timescale 1ns/1ps
module mem_slave
    import spi_link_pkg::*;
(
    // clock, reset, enable
    input  wire logic           ref_clk,
    input  wire logic           sys_rst,
    input  wire logic           ce,
    // link to the master
    spi_link_if.mem             link,
    // observation of internal state
    output logic                write_latch_flag,
    output logic [7:0]          status_view
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [4:0]            pin_raw;
    logic [4:0]            sync_a;
    logic [4:0]            sync_b;
    logic [4:0]            sync_c;
    logic [4:0]            pin;
    logic [4:0]            pin_prev;

    assign pin_raw = {link.wp_n, link.pause_n, link.mosi, link.sck, link.sel_n};

    // three stages; a level is taken only when the last two agree
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_a   <= PIN_IDLE;
            sync_b   <= PIN_IDLE;
            sync_c   <= PIN_IDLE;
            pin      <= PIN_IDLE;
            pin_prev <= PIN_IDLE;
        end else if (ce) begin
            sync_a   <= pin_raw;
            sync_b   <= sync_a;
            sync_c   <= sync_b;
            pin      <= (sync_b & ~(sync_b ^ sync_c)) | (pin & (sync_b ^ sync_c));
            pin_prev <= pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // edge and level decode

    logic                  held;
    logic                  selected;
    logic                  sck_rise;
    logic                  sck_fall;
    logic                  byte_done;
    logic [7:0]            rx_next;
    logic                  read_phase;

    assign held      = ~pin[PIN_PAUSE];
    assign selected  = ~pin[PIN_SEL] & ~held;
    // a clock step that arrives with select fall sets the mode, it is not a bit
    assign sck_rise  = selected & ~pin_prev[PIN_SEL] & pin[PIN_SCK] & ~pin_prev[PIN_SCK];
    assign sck_fall  = selected & ~pin_prev[PIN_SEL] & ~pin[PIN_SCK] & pin_prev[PIN_SCK];

    ////////////////////////////////////////////////////////////////////////////
    // command sequencer

    slave_state_type       state;
    logic [2:0]            bit_cnt;
    logic [6:0]            rx;
    logic [7:0]            tx;
    logic [ADDR_W-1:0]     addr;
    logic                  is_read;
    logic                  latch;
    logic                  wrote;
    logic                  out_live;
    logic [7:0]            stat_store;
    logic [7:0]            stat_now;
    logic                  mem_we;
    logic [7:0]            mem [MEM_DEPTH];

    // msb first, eight bits a group
    assign rx_next    = {rx, pin[PIN_SI]};
    assign byte_done  = sck_rise && (bit_cnt == LAST_BIT);
    assign read_phase = (state == st_read) || (state == st_stat_rd);

    // latch bit reads live, the stored copy of it is never used
    always_comb begin
        stat_now                 = stat_store;
        stat_now[STAT_LATCH_BIT] = latch;
    end

    // commit as soon as the byte completes
    assign mem_we = byte_done && (state == st_write) && latch;

    // all state lives in flops on ref_clk; a stopped sck only freezes it
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state      <= st_opcode;
            bit_cnt    <= 3'h0;
            rx         <= 7'h00;
            tx         <= 8'h00;
            addr       <= '0;
            is_read    <= 1'b0;
            latch      <= 1'b0;
            wrote      <= 1'b0;
            out_live   <= 1'b0;
            stat_store <= STAT_RESET;
        end else if (ce && !held) begin
            if (pin[PIN_SEL]) begin
                state    <= st_opcode;
                bit_cnt  <= 3'h0;
                out_live <= 1'b0;
                wrote    <= 1'b0;
                if (wrote) begin
                    latch <= 1'b0;
                end
            end else begin
                if (sck_fall && read_phase) begin
                    tx       <= {tx[6:0], 1'b0};
                    out_live <= 1'b1;
                end
                if (sck_rise) begin
                    rx      <= rx_next[6:0];
                    bit_cnt <= bit_cnt + 3'h1;
                end
                if (byte_done) begin
                    case (state)
                        st_opcode: begin
                            case (rx_next)
                                OP_SET_LATCH: begin
                                    latch <= 1'b1;
                                    state <= st_ignore;
                                end
                                OP_CLEAR_LATCH: begin
                                    latch <= 1'b0;
                                    state <= st_ignore;
                                end
                                OP_STATUS_RD: begin
                                    tx    <= stat_now;
                                    state <= st_stat_rd;
                                end
                                OP_STATUS_WR: begin
                                    state <= st_stat_wr;
                                end
                                OP_MEM_RD, OP_MEM_WR: begin
                                    is_read <= (rx_next == OP_MEM_RD);
                                    state   <= st_addr_hi;
                                end
                                default: begin
                                    state <= st_ignore;
                                end
                            endcase
                        end
                        st_addr_hi: begin
                            addr[ADDR_W-1:8] <= rx_next[ADDR_W-9:0];
                            state            <= st_addr_lo;
                        end
                        st_addr_lo: begin
                            if (is_read) begin
                                tx    <= mem[{addr[ADDR_W-1:8], rx_next}];
                                addr  <= {addr[ADDR_W-1:8], rx_next} + 13'h0001;
                                state <= st_read;
                            end else begin
                                addr[7:0] <= rx_next;
                                state     <= st_write;
                            end
                        end
                        st_write: begin
                            // next byte accepted at once, no busy
                            if (latch) begin
                                addr  <= addr + 13'h0001;
                                wrote <= 1'b1;
                            end
                        end
                        st_read: begin
                            // address wraps at the top of the array
                            tx   <= mem[addr];
                            addr <= addr + 13'h0001;
                        end
                        st_stat_rd: begin
                            tx <= stat_now;
                        end
                        st_stat_wr: begin
                            // protect pin low refuses status write
                            if (latch && pin[PIN_WP]) begin
                                stat_store <= rx_next;
                                wrote      <= 1'b1;
                            end
                            state <= st_ignore;
                        end
                        default: begin
                            state <= st_ignore;
                        end
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // array, no reset: contents survive and are not cleared

    always_ff @(posedge ref_clk) begin
        if (ce && !held && mem_we) begin
            mem[addr] <= rx_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial output

    // drive only in read data, never while paused or deselected
    // write states never enable the driver, so one wire may carry both
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            link.miso    <= 1'b0;
            link.miso_oe <= 1'b0;
        end else if (ce) begin
            if (sck_fall && read_phase) begin
                link.miso <= tx[7];
            end
            link.miso_oe <= selected && read_phase && (out_live || sck_fall);
        end
    end

    // modes 0 and 3 both rise to capture, so no mode detect is needed
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            write_latch_flag <= 1'b0;
            status_view      <= STAT_RESET;
        end else if (ce) begin
            write_latch_flag <= latch;
            status_view      <= stat_now;
        end
    end

endmodule

// file: core/spi_host.sv
`timescale 1ns/1ps
module spi_host
    import spi_link_pkg::*;
(
    // clock, reset, enable
    input  wire logic           ref_clk,
    input  wire logic           sys_rst,
    input  wire logic           ce,
    // link to the memory
    spi_link_if.host            link,
    // request
    input  wire logic           start,
    input  wire logic           mode3,
    input  wire logic [7:0]     opcode,
    input  wire logic [15:0]    addr,
    input  wire logic [7:0]     data_len,
    input  wire logic           pause,
    input  wire logic           protect,
    // data
    input  wire logic [7:0]     wr_data,
    output logic                wr_take,
    output logic [7:0]          rd_data,
    output logic                rd_valid,
    output logic                busy
);

    master_state_type      state;
    logic [7:0]            half_cnt;
    logic [2:0]            bit_cnt;
    logic [8:0]            byte_cnt;
    logic [8:0]            byte_total;
    logic [8:0]            hdr_len;
    logic [7:0]            tx;
    logic [6:0]            rx;
    logic                  idle_hi;
    logic [7:0]            op_q;
    logic [15:0]           addr_q;
    logic                  half_done;
    logic [7:0]            next_byte;

    assign half_done = (half_cnt == HALF_LAST);
    assign hdr_len   = has_address(op_q) ? 9'h003 : 9'h001;

    // byte source for the byte after the current one
    always_comb begin
        if (byte_cnt + 9'h001 == 9'h001 && has_address(op_q)) begin
            next_byte = addr_q[15:8];
        end else if (byte_cnt + 9'h001 == 9'h002 && has_address(op_q)) begin
            next_byte = addr_q[7:0];
        end else if (is_read_op(op_q)) begin
            next_byte = 8'h00;
        end else begin
            next_byte = wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer; sck divided from ref_clk, half period held while paused
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state        <= m_idle;
            half_cnt     <= 8'h00;
            bit_cnt      <= 3'h0;
            byte_cnt     <= 9'h000;
            byte_total   <= 9'h000;
            tx           <= 8'h00;
            rx           <= 7'h00;
            idle_hi      <= 1'b0;
            op_q         <= 8'h00;
            addr_q       <= 16'h0000;
            link.sel_n   <= 1'b1;
            link.sck     <= 1'b0;
            link.mosi    <= 1'b0;
            link.pause_n <= 1'b1;
            link.wp_n    <= 1'b1;
            wr_take      <= 1'b0;
            rd_data      <= 8'h00;
            rd_valid     <= 1'b0;
            busy         <= 1'b0;
        end else if (ce) begin
            wr_take   <= 1'b0;
            rd_valid  <= 1'b0;
            link.wp_n <= ~protect;
            half_cnt  <= half_done ? 8'h00 : half_cnt + 8'h01;
            case (state)
                m_idle: begin
                    half_cnt <= 8'h00;
                    if (start) begin
                        op_q       <= opcode;
                        addr_q     <= addr;
                        idle_hi    <= mode3;
                        byte_total <= (has_address(opcode) ? 9'h003 : 9'h001) + {1'b0, data_len};
                        byte_cnt   <= 9'h000;
                        bit_cnt    <= 3'h0;
                        tx         <= opcode;
                        link.sel_n <= 1'b0;
                        link.sck   <= mode3;
                        busy       <= 1'b1;
                        state      <= m_lead;
                    end
                end
                m_lead: begin
                    if (half_done) begin
                        link.sck  <= 1'b0;
                        link.mosi <= tx[7];
                        state     <= m_low;
                    end
                end
                m_low: begin
                    // pause moves only here, with sck low
                    if (pause) begin
                        link.pause_n <= 1'b0;
                        half_cnt     <= half_cnt;
                    end else if (!link.pause_n) begin
                        link.pause_n <= 1'b1;
                        half_cnt     <= 8'h00;
                    end else if (half_done) begin
                        link.sck <= 1'b1;
                        state    <= m_high;
                    end
                end
                m_high: begin
                    // miso sampled late in the high half, after the slave's sync delay
                    if (half_done) begin
                        rx      <= {rx[5:0], link.miso};
                        bit_cnt <= bit_cnt + 3'h1;
                        tx      <= {tx[6:0], 1'b0};
                        if (bit_cnt == LAST_BIT) begin
                            if (is_read_op(op_q) && byte_cnt >= hdr_len) begin
                                rd_data  <= {rx, link.miso};
                                rd_valid <= 1'b1;
                            end
                            byte_cnt <= byte_cnt + 9'h001;
                            if (byte_cnt + 9'h001 == byte_total) begin
                                link.sck <= idle_hi;
                                state    <= m_tail;
                            end else begin
                                tx        <= next_byte;
                                link.mosi <= next_byte[7];
                                link.sck  <= 1'b0;
                                wr_take   <= !is_read_op(op_q) && byte_cnt + 9'h001 >= hdr_len;
                                state     <= m_low;
                            end
                        end else begin
                            link.mosi <= tx[6];
                            link.sck  <= 1'b0;
                            state     <= m_low;
                        end
                    end
                end
                m_tail: begin
                    if (half_done) begin
                        link.sel_n <= 1'b1;
                        state      <= m_gap;
                    end
                end
                m_gap: begin
                    if (half_done) begin
                        busy  <= 1'b0;
                        state <= m_idle;
                    end
                end
                default: begin
                    state <= m_idle;
                end
            endcase
        end
    end

endmodule

// file: tb/spi_link_props.sv
`timescale 1ns/1ps
module spi_link_props (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // link pins
    input wire logic sel_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic pause_n,
    input wire logic wp_n
);
    logic [2:0] fall_age;
    logic [2:0] rises;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // cycles since the last sampled clock fall, saturating so idle gaps read as old
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            fall_age <= 3'h7;
        end else if ($past(sck) && !sck) begin
            fall_age <= 3'h0;
        end else if (fall_age != 3'h7) begin
            fall_age <= fall_age + 3'h1;
        end
    end

    // rising clock edges within a frame; the edge at select fall is a mode change, not a bit
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rises <= 3'h0;
        end else if (sel_n) begin
            rises <= 3'h0;
        end else if (!$past(sel_n) && !$past(sck) && sck) begin
            rises <= rises + 3'h1;
        end
    end

    chk_sel_quiet: assert property (sel_n [*6] |-> !miso_oe)
        else $error("output driven while deselected");
    chk_sel_release: assert property ($rose(sel_n) |-> ##[0:6] !miso_oe)
        else $error("output not released after deselect");
    chk_pause_freeze: assert property (!pause_n [*6] |-> !miso_oe && $stable(miso))
        else $error("output active during pause");
    chk_pause_release: assert property ($fell(pause_n) |-> ##[1:7] !miso_oe)
        else $error("output not released on pause");
    chk_miso_edge: assert property (($changed(miso) && miso_oe && $past(miso_oe)) |-> fall_age inside {[1:6]})
        else $error("output changed away from a clock fall");
    chk_pause_level: assert property ($changed(pause_n) |-> !sck)
        else $error("pause moved while clock high");
    chk_idle_clock: assert property ((sel_n && $past(sel_n)) |-> $stable(sck))
        else $error("clock moved between frames");
    chk_start_hold: assert property ($fell(sel_n) |=> $stable(sck) [*2])
        else $error("clock moved at frame start");
    chk_byte_frames: assert property ($rose(sel_n) |-> rises == 3'h0)
        else $error("frame not a whole number of bytes");
    chk_mosi_setup: assert property (($changed(mosi) && !sel_n) |-> !sck)
        else $error("data to memory moved while clock high");
endmodule

// file: tb/test_spi_nonvolatile_memory_slave.sv
`timescale 1ns/1ps
module test_spi_nonvolatile_memory_slave;
    import spi_link_pkg::*;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        ce = 1'b1;
    logic        start = 1'b0;
    logic        mode3 = 1'b0;
    logic        pause = 1'b0;
    logic        protect = 1'b0;
    logic [7:0]  opcode = 8'h00;
    logic [7:0]  data_len = 8'h00;
    logic [7:0]  wr_data = 8'h00;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  rd_data, status_view, stat;
    logic        wr_take, rd_valid, busy, write_latch_flag;
    logic [12:0] a;
    logic [7:0]  model [0:MEM_DEPTH-1];
    logic [7:0]  wq [$];
    logic [7:0]  rq [$];
    int          seed = 11904;
    int          miscompares = 0;
    int          num_checks = 0;
    int          n, len;

    always #20 ref_clk = ~ref_clk;

    spi_link_if link_i ();
    mem_slave mem_slave_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .link(link_i.mem),
        .write_latch_flag(write_latch_flag), .status_view(status_view));
    spi_host spi_host_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .link(link_i.host),
        .start(start), .mode3(mode3), .opcode(opcode), .addr(addr), .data_len(data_len), .pause(pause),
        .protect(protect), .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
        .busy(busy));
    spi_link_props spi_link_props_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .sel_n(link_i.sel_n),
        .sck(link_i.sck), .mosi(link_i.mosi), .miso(link_i.miso), .miso_oe(link_i.miso_oe),
        .pause_n(link_i.pause_n), .wp_n(link_i.wp_n));

    // feed write bytes on take, collect read bytes as they arrive
    always @(negedge ref_clk) begin
        if (rd_valid === 1'b1) rq.push_back(rd_data);
        if (wr_take === 1'b1 && wq.size() > 0) begin
            void'(wq.pop_front());
            wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
        end
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // status seen after a write: the latch bit is read only and cleared by the write
    function automatic logic [7:0] exp_stat(input logic [7:0] d);
        exp_stat = d;
        exp_stat[STAT_LATCH_BIT] = 1'b0;
    endfunction

    // one frame, random clock mode; waits until the host is idle again
    task xfer(input logic [7:0] op, input logic [15:0] ad, input logic [7:0] nb);
        @(negedge ref_clk);
        opcode = op;
        addr = ad;
        data_len = nb;
        mode3 = 1'($random(seed));
        wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        while (busy === 1'b1) @(negedge ref_clk);
    endtask

    task wr_mem(input logic [15:0] ad, input int nb, input logic en);
        logic [7:0] d;
        if (en) xfer(OP_SET_LATCH, 16'h0000, 8'h00);
        wq = {};
        for (int j = 0; j < nb; j++) begin
            d = 8'($random(seed));
            wq.push_back(d);
            if (en) model[ad[12:0] + 13'(j)] = d;
        end
        xfer(OP_MEM_WR, ad, 8'(nb));
    endtask

    task rd_mem(input logic [15:0] ad, input int nb);
        rq = {};
        xfer(OP_MEM_RD, ad, 8'(nb));
        check(8'(rq.size()), 8'(nb));
        for (int j = 0; j < nb; j++) check(rq[j], model[ad[12:0] + 13'(j)]);
    endtask

    task rd_stat(input logic [7:0] exp);
        rq = {};
        xfer(OP_STATUS_RD, 16'h0000, 8'h01);
        check(rq[0], exp);
        check(status_view, exp);
        check({7'h00, write_latch_flag}, {7'h00, exp[STAT_LATCH_BIT]});
    endtask

    task wr_stat(input logic [7:0] d);
        xfer(OP_SET_LATCH, 16'h0000, 8'h00);
        wq = {d};
        xfer(OP_STATUS_WR, 16'h0000, 8'h01);
    endtask

    // watchdog, far beyond the expected run of some 9k cycles
    initial begin
        #4000000;
        miscompares++;
        stop_test;
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        sys_rst = 1'b0;
        stat = STAT_RESET;
        rd_stat(stat);
        // random writes, read back with random ignored top address bits
        for (n = 0; n < 6; n++) begin
            a = 13'($random(seed));
            len = 1 + ($random(seed) & 3);
            wr_mem({3'h0, a}, len, 1'b1);
            rd_mem({3'($random(seed)), a}, len);
            rd_stat(stat);
        end
        $display("random writes done");
        // wrap over the top of the array, then a write without the latch is dropped
        wr_mem(16'hFFFF, 3, 1'b1);
        rd_mem(16'h1FFF, 3);
        wr_mem(16'h1FFF, 2, 1'b0);
        rd_mem(16'h1FFF, 3);
        $display("wrap and refusal done");
        // latch set, then cleared by command
        xfer(OP_SET_LATCH, 16'h0000, 8'h00);
        rd_stat(stat | 8'h02);
        xfer(OP_CLEAR_LATCH, 16'h0000, 8'h00);
        rd_stat(stat);
        // protect pin blocks a status write and leaves the latch set
        protect = 1'b1;
        wr_stat(8'hFF);
        rd_stat(stat | 8'h02);
        protect = 1'b0;
        wr_stat(8'hFF);
        stat = exp_stat(8'hFF);
        rd_stat(stat);
        $display("latch and status done");
        // pause in the middle of a read must not lose the transfer
        fork
            rd_mem(16'h1FFF, 3);
            begin
                repeat (220) @(negedge ref_clk);
                pause = 1'b1;
                repeat (40) @(negedge ref_clk);
                pause = 1'b0;
            end
        join
        $display("pause done");
        stop_test;
    end
endmodule
